/* hw/ccs_command_status.sv */
// design: command decode and status byte of the CAN controller
`timescale 1ns/100ps
`default_nettype none

// How it works
// [R1] sleep request enters sleep only with no pending interrupt and quiet bus
// [R2] sleep request refused under activity or pending interrupt raises wake-up interrupt
// [R3] clock output keeps running at least 15 bit times after sleep starts
// [R4] sleep ends on request clear, bus activity or interrupt low; wake interrupt
// [R5] after waking by bus activity, reception waits for one bus-free sequence
// [R6] sleep request ignored in reset mode; allowed again after next bus-free
// [R7] clear-overrun written as one clears overrun flag; zero does nothing
// [R8] no further overrun interrupt while the overrun flag stays set
// [R9] clear-overrun and release-slot in one write both take effect
// [R10] release frees slot; another message raises receive interrupt, else available clears
// [R11] abort cancels a waiting transmission; one in progress completes
// [R12] host waits for buffer free, then checks done flag after abort
// [R13] send request starts transmission; writing zero later cancels nothing
// [R14] status bit 7 shows bus-off
// [R15] status bit 6 shows either error counter at or above warning limit
// [R16] status bits 5 and 4 show transmit and receive activity
// [R17] status bit 3 set only once last requested transmission succeeded
// [R18] status bit 2 shows buffer writable; buffer access blocked otherwise
// [R19] status bit 1 sets on lost message, holds until clear-overrun
// [R20] status bit 0 shows messages held in the receive queue
// [R21] status byte read only; writes to it change nothing
// [R22] command register write only; reads return all ones
// [R23] host leaves one internal clock cycle between command writes
// [R24] done flag clears on each send request until a successful transmission
// [R25] warning limit 96; change of warning or bus-off raises error interrupt
// [R26] commands other than sleep act as single-cycle pulses
module ccs_command_status
  import ccs_pkg::*;
#(
  parameter int ERR_W   = 9,
  parameter int COUNT_W = 6
) (
  // apb slave
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // bus and controller state
  input  wire logic               bus_activity,
  input  wire logic               irq_pending,
  input  wire logic               int_pin_low,
  input  wire logic               reset_mode,
  input  wire logic               bus_free,
  input  wire logic               bit_tick,
  input  wire logic               bus_off,
  input  wire logic [ERR_W-1:0]   tx_err_count,
  input  wire logic [ERR_W-1:0]   rx_err_count,
  // transfer layer
  input  wire logic               tx_running,
  input  wire logic               tx_started,
  input  wire logic               tx_success,
  input  wire logic               rx_running,
  input  wire logic               rx_lost,
  input  wire logic [COUNT_W-1:0] rx_count,
  // interrupt enables
  input  wire logic               overrun_irq_en,
  input  wire logic               rx_irq_en,
  input  wire logic               err_irq_en,
  // command pulses and interrupt requests
  output ccs_pulse_type           cmd_pulse,
  output ccs_irq_type             irq_pulse,
  // sleep, clock and receive gating
  output logic                    clock_output_en,
  output logic                    osc_run,
  output logic                    rx_enable,
  output logic                    tx_buf_lock,
  output ccs_status_type          status_reg
);

  if (ERR_W < 8 || COUNT_W < 1) begin
    $error("ccs_command_status: unsupported parameter value");
  end

  // ************************************************************
  // signals
  // ************************************************************
  logic            int_tick_q;
  logic            wr_cmd;
  logic            cmd_valid_q;
  logic [4:0]      cmd_q;
  logic            sleep_request_q;
  logic            sleep_allowed_q;
  logic            rx_hold_q;
  logic            tx_pending_q;
  logic [3:0]      bit_cnt_q;
  ccs_sleep_type   sleep_state_q;
  ccs_status_type  stat_d;
  logic            warn_now;
  logic            sleep_blocked;
  logic            wake_cond;
  logic            go_sleep_now;
  logic            refuse_sleep;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] base);
    addr_hit = (a == base);
  endfunction

  // ************************************************************
  // internal clock at half rate
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_tick_q <= CCS_DIV_RESET;
    end else begin
      int_tick_q <= ~int_tick_q;
    end
  end

  // ************************************************************
  // apb slave
  // ************************************************************
  assign wr_cmd = psel & penable & pready & pwrite & addr_hit(paddr, CCS_CMD_ADDR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= CCS_ZERO_READ;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= CCS_ZERO_READ;
      if (psel && !penable) begin
        if (addr_hit(paddr, CCS_CMD_ADDR)) begin
          // [R22] command reads all ones
          prdata <= pwrite ? CCS_ZERO_READ : CCS_CMD_READ;
        end else if (addr_hit(paddr, CCS_STAT_ADDR)) begin
          // [R21] status read only
          prdata <= pwrite ? CCS_ZERO_READ : {24'h00_0000, status_reg};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // command capture, issued on internal clock
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_valid_q <= 1'b0;
      cmd_q       <= 5'h00;
    end else if (wr_cmd) begin
      cmd_valid_q <= 1'b1;
      cmd_q       <= pwdata[4:0];
    end else if (int_tick_q) begin
      cmd_valid_q <= 1'b0;
    end
  end

  // ************************************************************
  // one-cycle command pulses
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pulse <= '0;
    end else begin
      // [R26] single cycle pulses
      cmd_pulse <= '0;
      if (cmd_valid_q && int_tick_q) begin
        // [R13] send on one only
        cmd_pulse.send_request    <= cmd_q[CCS_CMD_SEND];
        // [R11] abort only when waiting
        cmd_pulse.abort_tx        <= cmd_q[CCS_CMD_ABORT] & tx_pending_q & ~tx_running;
        // [R9] both commands together
        cmd_pulse.release_rx_slot <= cmd_q[CCS_CMD_RELEASE];
        cmd_pulse.clear_overrun   <= cmd_q[CCS_CMD_CLR_OVR];
      end
    end
  end

  // ************************************************************
  // transmit request tracking
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pending_q <= 1'b0;
    end else if (cmd_pulse.send_request) begin
      tx_pending_q <= 1'b1;
    end else if (tx_started || cmd_pulse.abort_tx) begin
      // [R11] in-progress frame not stopped
      tx_pending_q <= 1'b0;
    end
  end

  // ************************************************************
  // sleep control
  // ************************************************************
  assign sleep_blocked = bus_activity | irq_pending;
  assign wake_cond     = ~sleep_request_q | bus_activity | int_pin_low;
  assign go_sleep_now  = cmd_valid_q & int_tick_q & cmd_q[CCS_CMD_SLEEP] & sleep_allowed_q;
  assign refuse_sleep  = go_sleep_now & sleep_blocked & (sleep_state_q == CCS_AWAKE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_allowed_q <= 1'b0;
    end else if (reset_mode) begin
      // [R6] re-armed by bus-free after reset mode
      sleep_allowed_q <= 1'b0;
    end else if (bus_free) begin
      sleep_allowed_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_request_q <= 1'b0;
    end else if (reset_mode) begin
      // [R6] no sleep in reset mode
      sleep_request_q <= 1'b0;
    end else if (cmd_valid_q && int_tick_q) begin
      // [R1] stored only when accepted
      sleep_request_q <= cmd_q[CCS_CMD_SLEEP] & sleep_allowed_q & ~sleep_blocked;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_state_q <= CCS_AWAKE;
      bit_cnt_q     <= 4'h0;
    end else begin
      case (sleep_state_q)
        CCS_AWAKE: begin
          bit_cnt_q <= 4'h0;
          // [R1] quiet bus, nothing pending
          if (sleep_request_q && !sleep_blocked && !int_pin_low) begin
            sleep_state_q <= CCS_SLEEP_CLK;
          end
        end
        CCS_SLEEP_CLK: begin
          if (wake_cond) begin
            sleep_state_q <= CCS_AWAKE;
          end else if (bit_tick) begin
            // [R3] run clock for 15 bit times
            if (bit_cnt_q == CCS_SLEEP_CLK_BITS - 4'h1) begin
              sleep_state_q <= CCS_SLEEP;
            end
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        CCS_SLEEP: begin
          // [R4] wake on any negated condition
          if (wake_cond) begin
            sleep_state_q <= CCS_AWAKE;
          end
        end
        default: begin
          sleep_state_q <= CCS_AWAKE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_output_en <= 1'b1;
      osc_run         <= 1'b1;
    end else begin
      // [R3] hold clock output low only after count
      clock_output_en <= (sleep_state_q != CCS_SLEEP);
      // [R4] oscillator restarts on wake
      osc_run         <= (sleep_state_q != CCS_SLEEP) | wake_cond;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hold_q <= 1'b0;
      rx_enable <= 1'b1;
    end else begin
      // [R5] wait for bus-free after activity wake
      if (sleep_state_q != CCS_AWAKE && bus_activity) begin
        rx_hold_q <= 1'b1;
      end else if (bus_free) begin
        rx_hold_q <= 1'b0;
      end
      rx_enable <= ~rx_hold_q & ~(sleep_state_q != CCS_AWAKE && bus_activity);
    end
  end

  // ************************************************************
  // status flags
  // ************************************************************
  // [R25] limit of 96 on either counter
  assign warn_now = (tx_err_count >= ERR_W'(CCS_WARN_LIMIT)) |
                    (rx_err_count >= ERR_W'(CCS_WARN_LIMIT));

  always_comb begin
    stat_d = status_reg;
    // [R14] bus-off
    stat_d.bus_off_flag   = bus_off;
    // [R15] error warning
    stat_d.error_warning  = warn_now;
    // [R16] activity bits
    stat_d.tx_active      = tx_running;
    stat_d.rx_active      = rx_running;
    // [R24] cleared by send, set by success
    if (tx_success) begin
      stat_d.tx_done = 1'b1;
    end else if (cmd_pulse.send_request) begin
      stat_d.tx_done = 1'b0;
    end
    // [R17] done stays clear until success
    if (tx_pending_q && !tx_success) begin
      stat_d.tx_done = 1'b0;
    end
    // [R18] buffer free when nothing waits or runs
    stat_d.tx_buffer_free = ~(tx_pending_q | cmd_pulse.send_request | tx_running);
    // [R19] set wins over clear
    if (rx_lost) begin
      stat_d.overrun_flag = 1'b1;
    end else if (cmd_pulse.clear_overrun) begin
      // [R7] clear only on written one
      stat_d.overrun_flag = 1'b0;
    end
    // [R20] messages held
    stat_d.rx_available = (rx_count != '0);
    // [R10] released last message clears
    if (cmd_pulse.release_rx_slot && rx_count <= COUNT_W'(1)) begin
      stat_d.rx_available = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg  <= CCS_STATUS_RESET;
      tx_buf_lock <= 1'b0;
    end else begin
      status_reg  <= stat_d;
      // [R18] host buffer access blocked
      tx_buf_lock <= ~stat_d.tx_buffer_free;
    end
  end

  // ************************************************************
  // interrupt request pulses
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pulse <= '0;
    end else begin
      // [R2] [R4] refused sleep or wake-up
      irq_pulse.wake    <= refuse_sleep |
                           ((sleep_state_q != CCS_AWAKE) & wake_cond);
      // [R8] only on rising overrun
      irq_pulse.overrun <= overrun_irq_en & rx_lost & ~status_reg.overrun_flag;
      // [R10] another message after release
      irq_pulse.receive <= rx_irq_en & cmd_pulse.release_rx_slot & (rx_count > COUNT_W'(1));
      // [R25] warning or bus status change
      irq_pulse.error   <= err_irq_en &
                           ((warn_now != status_reg.error_warning) |
                            (bus_off != status_reg.bus_off_flag));
    end
  end

endmodule

`default_nettype wire

/* hw/ccs_pkg.sv */
// package: constants and carriers for the command and status logic
package ccs_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] CCS_CMD_INDEX  = 8'h01;
  localparam logic [7:0] CCS_STAT_INDEX = 8'h02;
  localparam logic [7:0] CCS_CMD_ADDR   = 8'(CCS_CMD_INDEX * 4);
  localparam logic [7:0] CCS_STAT_ADDR  = 8'(CCS_STAT_INDEX * 4);
  localparam logic [31:0] CCS_CMD_READ  = 32'h0000_00ff;
  localparam logic [31:0] CCS_ZERO_READ = 32'h0000_0000;

  // ************************************************************
  // command bit positions
  // ************************************************************
  localparam int CCS_CMD_SEND    = 0;
  localparam int CCS_CMD_ABORT   = 1;
  localparam int CCS_CMD_RELEASE = 2;
  localparam int CCS_CMD_CLR_OVR = 3;
  localparam int CCS_CMD_SLEEP   = 4;

  // ************************************************************
  // limits and counts
  // ************************************************************
  localparam logic [7:0] CCS_WARN_LIMIT    = 8'h60;
  localparam logic [3:0] CCS_SLEEP_CLK_BITS = 4'hf;
  localparam logic       CCS_DIV_RESET      = 1'b0;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic bus_off_flag;
    logic error_warning;
    logic tx_active;
    logic rx_active;
    logic tx_done;
    logic tx_buffer_free;
    logic overrun_flag;
    logic rx_available;
  } ccs_status_type;

  localparam ccs_status_type CCS_STATUS_RESET = 8'h0c;

  typedef struct packed {
    logic send_request;
    logic abort_tx;
    logic release_rx_slot;
    logic clear_overrun;
  } ccs_pulse_type;

  typedef struct packed {
    logic wake;
    logic overrun;
    logic receive;
    logic error;
  } ccs_irq_type;

  typedef enum {
    CCS_AWAKE,
    CCS_SLEEP_CLK,
    CCS_SLEEP
  } ccs_sleep_type;

endpackage

/* tb/ccs_host_model.sv */
// partner: apb host issuing register transfers
`timescale 1ns/100ps
`default_nettype none
module ccs_host_model (
  // apb master side
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // bounded wait ran out
  output logic             hung
);
  // ************
  // transfers
  // ************
  initial begin
    {psel, penable, pwrite, hung} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    hung <= (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    repeat (2) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* tb/ccs_monitor.sv */
// checker: port assertions for the command and status logic
`timescale 1ns/100ps
`default_nettype none
module ccs_monitor
  import ccs_pkg::*;
#(
  parameter int ERR_W = 9
) (
  // apb side
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  // controller side
  input wire logic             bus_off,
  input wire logic             bus_activity,
  input wire logic             bit_tick,
  input wire logic             rx_lost,
  input wire logic             tx_running,
  input wire logic             rx_running,
  input wire logic [ERR_W-1:0] tx_err_count,
  input wire logic [ERR_W-1:0] rx_err_count,
  input wire ccs_pulse_type    cmd_pulse,
  input wire ccs_irq_type      irq_pulse,
  input wire logic             clock_output_en,
  input wire ccs_status_type   status_reg
);
  // ************
  // assertions
  // ************
  logic [4:0] ticks_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ticks_q <= 5'h00;
    end else if (pready && pwrite && paddr == CCS_CMD_ADDR) begin
      ticks_q <= 5'h00;
    end else if (bit_tick && ticks_q != 5'h1f) begin
      ticks_q <= ticks_q + 5'h01;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_cmd_read;
    pready && !pwrite && paddr == CCS_CMD_ADDR |-> prdata == CCS_CMD_READ;
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command read not ones");
  property p_pulse; cmd_pulse != '0 |=> cmd_pulse == '0; endproperty
  a_pulse: assert property (p_pulse) else $error("command pulse held");
  property p_send;
    cmd_pulse.send_request |=> !status_reg.tx_done && !status_reg.tx_buffer_free;
  endproperty
  a_send: assert property (p_send) else $error("send left done or free set");
  property p_lost; rx_lost |=> status_reg.overrun_flag; endproperty
  a_lost: assert property (p_lost) else $error("overrun flag not set");
  property p_reovr;
    status_reg.overrun_flag && $past(status_reg.overrun_flag) |-> !irq_pulse.overrun;
  endproperty
  a_reovr: assert property (p_reovr) else $error("repeated overrun interrupt");
  property p_clr;
    cmd_pulse.clear_overrun && !rx_lost |-> ##[0:2] !status_reg.overrun_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("overrun not cleared");
  property p_warn; 1'b1 |=> status_reg.error_warning == ($past(tx_err_count) >= CCS_WARN_LIMIT
    || $past(rx_err_count) >= CCS_WARN_LIMIT); endproperty
  a_warn: assert property (p_warn) else $error("warning flag wrong");
  property p_boff; 1'b1 |=> status_reg.bus_off_flag == $past(bus_off); endproperty
  a_boff: assert property (p_boff) else $error("bus-off flag wrong");
  property p_act;
    1'b1 |=> {status_reg.tx_active, status_reg.rx_active} == $past({tx_running, rx_running});
  endproperty
  a_act: assert property (p_act) else $error("activity flags wrong");
  property p_clk; $fell(clock_output_en) |-> ticks_q >= 5'h0f; endproperty
  a_clk: assert property (p_clk) else $error("clock output stopped early");
  property p_wake; $rose(bus_activity) && !clock_output_en |-> ##[1:6] irq_pulse.wake; endproperty
  a_wake: assert property (p_wake) else $error("no wake pulse");
endmodule
bind ccs_command_status ccs_monitor #(.ERR_W(ERR_W)) u_monitor (.pclk, .presetn, .pwrite,
  .paddr, .prdata, .pready, .bus_off, .bus_activity, .bit_tick, .rx_lost, .tx_running,
  .rx_running, .tx_err_count, .rx_err_count, .cmd_pulse, .irq_pulse, .clock_output_en,
  .status_reg);
`default_nettype wire

/* tb/tb_ccs_command_status.sv */
// testbench: directed scenarios for the command and status logic
`timescale 1ns/100ps
`default_nettype none
module tb_ccs_command_status
  import ccs_pkg::*;
();
  // ************
  // bench
  // ************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung, err_q;
  logic bus_activity, irq_pending, int_pin_low, reset_mode, bus_free, bit_tick;
  logic bus_off, tx_running, tx_started, tx_success, rx_running, rx_lost;
  logic clock_output_en, osc_run, rx_enable, tx_buf_lock;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [8:0] tx_err_count, rx_err_count;
  logic [5:0] rx_count;
  ccs_pulse_type cmd_pulse;
  ccs_irq_type irq_pulse;
  ccs_status_type status_reg;
  int num_errors = 0;
  int n_checks = 0;
  int n_rx_irq = 0;
  int n_err_irq = 0;
  int n_ovr_irq = 0;

  ccs_command_status u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus_activity, .irq_pending, .int_pin_low, .reset_mode,
    .bus_free, .bit_tick, .bus_off, .tx_err_count, .rx_err_count, .tx_running, .tx_started,
    .tx_success, .rx_running, .rx_lost, .rx_count, .overrun_irq_en(1'b1), .rx_irq_en(1'b1),
    .err_irq_en(1'b1), .cmd_pulse, .irq_pulse, .clock_output_en, .osc_run, .rx_enable,
    .tx_buf_lock, .status_reg);
  ccs_host_model u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hung);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge hung) begin
    num_errors++;
    complete_run();
  end
  always @(posedge pclk) begin
    n_rx_irq += int'(irq_pulse.receive === 1'b1);
    n_err_irq += int'(irq_pulse.error === 1'b1);
    n_ovr_irq += int'(irq_pulse.overrun === 1'b1);
  end

  task automatic complete_run();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [31:0] d);
    u_host.xfer(1'b1, CCS_CMD_ADDR, d, rd_q, err_q);
  endtask
  task automatic rd_stat(input logic [7:0] exp);
    u_host.xfer(1'b0, CCS_STAT_ADDR, 32'h0, rd_q, err_q);
    chk_word(rd_q, {24'h0, exp});
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk) bit_tick <= 1'b1;
      @(posedge pclk) bit_tick <= 1'b0;
    end
  endtask
  task automatic wait_wake();
    int n;
    n = 0;
    while (irq_pulse.wake !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    n_checks++;
    if (n == 20) begin
      num_errors++;
      complete_run();
    end
  endtask

  task automatic sc_regs();
    u_host.xfer(1'b0, CCS_CMD_ADDR, 32'h0, rd_q, err_q);
    chk_word(rd_q, CCS_CMD_READ);
    rd_stat(8'h0c);
    u_host.xfer(1'b1, CCS_STAT_ADDR, 32'h0000_00ff, rd_q, err_q);
    rd_stat(8'h0c);
    u_host.xfer(1'b0, 8'h10, 32'h0, rd_q, err_q);
    chk_bit(err_q, 1'b1);
  endtask
  task automatic sc_send_abort();
    wr(32'h0000_0001);
    rd_stat(8'h00);
    chk_bit(tx_buf_lock, 1'b1);
    wr(32'h0000_0000);
    rd_stat(8'h00);
    wr(32'h0000_0002);
    @(posedge pclk);
    rd_stat(8'h04);
    chk_bit(tx_buf_lock, 1'b0);
  endtask
  task automatic sc_tx_run();
    wr(32'h0000_0001);
    @(posedge pclk) tx_started <= 1'b1;
    tx_running <= 1'b1;
    @(posedge pclk) tx_started <= 1'b0;
    wr(32'h0000_0002);
    rd_stat(8'h20);
    @(posedge pclk) tx_running <= 1'b0;
    tx_success <= 1'b1;
    @(posedge pclk) tx_success <= 1'b0;
    rd_stat(8'h0c);
  endtask
  task automatic sc_rx();
    @(posedge pclk) rx_count <= 6'h02;
    repeat (2) begin
      @(posedge pclk) rx_lost <= 1'b1;
      @(posedge pclk) rx_lost <= 1'b0;
    end
    rd_stat(8'h0f);
    wr(32'h0000_0000);
    rd_stat(8'h0f);
    wr(32'h0000_000c);
    rd_stat(8'h0d);
    @(posedge pclk) rx_count <= 6'h01;
    wr(32'h0000_0004);
    @(posedge pclk) rx_count <= 6'h00;
    rd_stat(8'h0c);
    chk_word(n_ovr_irq, 32'h1);
    chk_word(n_rx_irq, 32'h1);
  endtask
  task automatic sc_err();
    logic [8:0] tv [4] = '{9'h05f, 9'h060, 9'h0ff, 9'h000};
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk) tx_err_count <= tv[i];
      rx_err_count <= tv[3-i];
      rd_stat((tv[i] >= CCS_WARN_LIMIT || tv[3-i] >= CCS_WARN_LIMIT) ? 8'h4c : 8'h0c);
    end
    @(posedge pclk) bus_off <= 1'b1;
    rx_running <= 1'b1;
    rd_stat(8'h9c);
    @(posedge pclk) bus_off <= 1'b0;
    rx_running <= 1'b0;
    rd_stat(8'h0c);
    chk_word(n_err_irq, 32'h4);
  endtask
  task automatic sc_sleep();
    @(posedge pclk) bus_free <= 1'b1;
    @(posedge pclk) bus_free <= 1'b0;
    wr(32'h0000_0010);
    ticks(14);
    chk_bit(clock_output_en, 1'b1);
    ticks(3);
    @(posedge pclk);
    chk_bit(clock_output_en, 1'b0);
    @(posedge pclk) bus_activity <= 1'b1;
    wait_wake();
    repeat (2) @(posedge pclk);
    chk_bit(osc_run, 1'b1);
    chk_bit(clock_output_en, 1'b1);
    chk_bit(rx_enable, 1'b0);
    wr(32'h0000_0000);
    @(posedge pclk) bus_activity <= 1'b0;
    bus_free <= 1'b1;
    @(posedge pclk) bus_free <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_bit(rx_enable, 1'b1);
  endtask
  task automatic sc_refuse();
    @(posedge pclk) irq_pending <= 1'b1;
    wr(32'h0000_0010);
    wait_wake();
    wr(32'h0000_0000);
    @(posedge pclk) irq_pending <= 1'b0;
    reset_mode <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(32'h0000_0010);
      ticks(17);
      chk_bit(clock_output_en, 1'b1);
      @(posedge pclk) reset_mode <= 1'b0;
    end
    wr(32'h0000_0000);
  endtask

  initial begin
    presetn = 1'b0;
    {bus_activity, irq_pending, int_pin_low, reset_mode, bus_free, bit_tick} = 6'h00;
    {bus_off, tx_running, tx_started, tx_success, rx_running, rx_lost} = 6'h00;
    {tx_err_count, rx_err_count, rx_count} = 24'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    sc_regs();
    sc_send_abort();
    sc_tx_run();
    sc_rx();
    sc_err();
    sc_sleep();
    sc_refuse();
    complete_run();
  end
endmodule
`default_nettype wire
